/* File: rcs_chk.sv */
/* Port assertions for rcs_reset_cause.
 * Bound by port name; needs rcs_pkg. */
`timescale 1ns/10ps
module rcs_chk
	import rcs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire rcs_event_t hw_event,
	input wire logic [2:0] clock_source_sel
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire rd = psel && !pwrite && paddr == RCS_OFF_FLAGS;
	property p_tr; hw_event[8] ##1 rd |-> prdata[15]; endproperty
	a_tr: assert property (p_tr) else $error("trap");
	property p_il; hw_event[7] ##1 rd |-> prdata[14]; endproperty
	a_il: assert property (p_il) else $error("illop");
	property p_pn; hw_event[6] ##1 rd |-> prdata[7]; endproperty
	a_pn: assert property (p_pn) else $error("pin");
	property p_sl; hw_event == 9'h008 ##1 rd |-> prdata[4:3] == 2'h1; endproperty
	a_sl: assert property (p_sl) else $error("sleep");
	property p_id; hw_event[2] ##1 rd |-> prdata[2]; endproperty
	a_id: assert property (p_id) else $error("idle");
	property p_po; hw_event == 9'h001 ##1 rd |-> prdata[15:0] == 16'h3; endproperty
	a_po: assert property (p_po) else $error("por");
	property p_bo; hw_event == 9'h002 ##1 rd
		|-> (prdata[15:0] & 16'hC05E) == 16'h2; endproperty
	a_bo: assert property (p_bo) else $error("bor");
	property p_cs; hw_event[6:4] == 3'h0 && hw_event[1:0] == 2'h0
		|=> $stable(clock_source_sel); endproperty
	a_cs: assert property (p_cs) else $error("clksel");
endmodule : rcs_chk
bind rcs_reset_cause rcs_chk u_chk (.*);

/* File: rcs_pkg.sv */
/*
 * Package for the reset-cause and reset clock-select block: register
 * offsets, flag bit positions, reset values and the event carrier.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
package rcs_pkg;

	localparam logic [11:0] RCS_OFF_FLAGS = 12'h000;
	localparam logic [11:0] RCS_OFF_CLKCFG = 12'h004;
	localparam logic [11:0] RCS_OFF_CLKSEL = 12'h008;

	localparam int RCS_BIT_TRAP = 15;
	localparam int RCS_BIT_ILLOP = 14;
	localparam int RCS_BIT_EXTPIN = 7;
	localparam int RCS_BIT_SWRST = 6;
	localparam int RCS_BIT_WATCHDOG_TIMEOUT_FLAG = 4;
	localparam int RCS_BIT_SLEEP = 3;
	localparam int RCS_BIT_IDLE = 2;
	localparam int RCS_BIT_BOR = 1;
	localparam int RCS_BIT_POR = 0;

	localparam logic [15:0] RCS_FLAGS_IMPL = 16'hC0DF;
	localparam logic [15:0] RCS_FLAGS_RESET = 16'h0003;
	localparam logic [2:0] RCS_OSC_RESET = 3'h0;
	localparam int RCS_CLKSW_BIT = 3;

	typedef struct packed {
		logic trap_conflict;
		logic illegal_op;
		logic pin_reset;
		logic reset_instr;
		logic watchdog_expire;
		logic sleep_instr;
		logic idle_instr;
		logic brownout_reset;
		logic poweron_reset;
	} rcs_event_t;

endpackage : rcs_pkg

/* File: rcs_reset_cause.sv */
/*
 * Reset-cause flag register with reset-time system clock source selection,
 * reached over APB. Assumes event inputs are one-cycle pulses from logic on
 * core_clk and that reset causes are reported as pulses after core reset.
 */
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
module rcs_reset_cause
	import rcs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rcs_event_t hw_event,
	input wire logic [2:0] current_oscillator_bits,
	output logic [2:0] clock_source_sel
);

	logic [15:0] reset_cause_flags_r;
	logic [15:0] flags_nxt;
	logic [2:0] osc_cfg_r;
	logic clk_switch_en_r;
	logic [2:0] clk_sel_r;

	wire wr_acc = psel && penable && pwrite;
	wire hit_flags = (paddr == RCS_OFF_FLAGS);
	wire hit_cfg = (paddr == RCS_OFF_CLKCFG);
	wire hit_sel = (paddr == RCS_OFF_CLKSEL);
	wire hit_any = hit_flags || hit_cfg || hit_sel;
	wire wr_flags = wr_acc && hit_flags;
	wire wr_cfg = wr_acc && hit_cfg;
	wire por_or_bor = hw_event.poweron_reset || hw_event.brownout_reset;
	wire warm_reset = hw_event.pin_reset || hw_event.watchdog_expire
		|| hw_event.reset_instr;

	wire [15:0] set_mask = {
		hw_event.trap_conflict,
		hw_event.illegal_op,
		6'h00,
		hw_event.pin_reset,
		hw_event.reset_instr,
		1'b0,
		hw_event.watchdog_expire,
		hw_event.sleep_instr,
		hw_event.idle_instr,
		por_or_bor,
		hw_event.poweron_reset
	};

	// Power-on and brown-out wipe causes, but brown-out keeps the pin flag.
	wire [15:0] clr_mask = {
		por_or_bor,
		por_or_bor,
		6'h00,
		hw_event.poweron_reset,
		por_or_bor,
		1'b0,
		por_or_bor || hw_event.sleep_instr || hw_event.idle_instr,
		por_or_bor,
		por_or_bor,
		2'b00
	};

	// Write first, then clear, then set: a set always lands last.
	always_comb begin
		flags_nxt = reset_cause_flags_r;
		if (wr_flags) begin
			flags_nxt = pwdata[15:0] & RCS_FLAGS_IMPL;
		end
		flags_nxt = (flags_nxt & ~clr_mask) | set_mask;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reset_cause_flags_r <= RCS_FLAGS_RESET;
		end else begin
			reset_cause_flags_r <= flags_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			osc_cfg_r <= RCS_OSC_RESET;
			clk_switch_en_r <= 1'b0;
		end else if (wr_cfg) begin
			osc_cfg_r <= pwdata[2:0];
			clk_switch_en_r <= pwdata[RCS_CLKSW_BIT];
		end
	end

	// The selection is latched only at a reset event, so later writes to the
	// configuration field take effect at the next power-on, brown-out, or warm reset with clk_switch_en_r clear, not immediately.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			clk_sel_r <= RCS_OSC_RESET;
		end else if (por_or_bor || (warm_reset && !clk_switch_en_r)) begin
			clk_sel_r <= osc_cfg_r;
		end else if (warm_reset) begin
			clk_sel_r <= current_oscillator_bits;
		end
	end

	assign clock_source_sel = clk_sel_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_flags) begin
			prdata = {16'h0000, reset_cause_flags_r};
		end else if (hit_cfg) begin
			prdata = {28'h000_0000, clk_switch_en_r, osc_cfg_r};
		end else if (hit_sel) begin
			prdata = {29'h0000_0000, clk_sel_r};
		end
	end

endmodule : rcs_reset_cause

/* File: rcs_reset_cause_test.sv */
/* Bench for rcs_reset_cause: APB master and event pulses.
 * Needs rcs_pkg and rcs_chk compiled first. */
`timescale 1ns/10ps
module rcs_reset_cause_test
	import rcs_pkg::*;
;
	logic core_clk = '0, reset = '1, psel = '0, penable = '0, pwrite = '0;
	logic pready, pslverr, s;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic [2:0] current_oscillator_bits = 3'h2, clock_source_sel;
	logic [15:0] e = 16'h8000;
	rcs_event_t hw_event = '0;
	int n_errors = 0, checks_done = 0, bp[9] = '{0, 1, 2, 3, 4, 6, 7, 14, 15};
	rcs_reset_cause dut (.*);
	initial forever #20 core_clk = ~core_clk;
	initial begin repeat (3000) @(posedge core_clk); n_errors++; end_sim; end
	task chk(string n, logic [31:0] x, g);
		checks_done++;
		if (g !== x) n_errors++;
		if (g !== x) $display("MISMATCH %s exp %h got %h", n, x, g);
	endtask : chk
	task ev(rcs_event_t v); @(posedge core_clk); hw_event <= v; endtask : ev
	task apb(logic w, logic [11:0] a, logic [31:0] d, rcs_event_t v = '0);
		@(posedge core_clk);
		{psel, pwrite, paddr, pwdata, hw_event} <= {1'h1, w, a, d, 9'h0};
		@(posedge core_clk);
		{penable, hw_event} <= {1'h1, v};
		do @(posedge core_clk); while (pready !== 1'h1);
		{q, s} = {prdata, pslverr};
		{psel, penable, hw_event} <= '0;
	endtask : apb
	task rf; apb(1'h0, RCS_OFF_FLAGS, 32'h0); endtask : rf
	task rs; apb(1'h0, RCS_OFF_CLKSEL, 32'h0); endtask : rs
	task t_flags;
		rf; chk("reset", 32'h3, q);
		apb(1'h0, 12'h00C, 32'h0); chk("unmapped", 32'h1, {31'h0, s});
		apb(1'h1, RCS_OFF_FLAGS, 32'hFFFF); rf; chk("all", 32'hC0DF, q);
		apb(1'h1, RCS_OFF_FLAGS, 32'h0, 9'h100);
		rf; chk("prio", 32'h8000, q);
		for (int i = 8; i >= 0; i--) begin
			ev(9'h1 << i);
			e[bp[i]] = 1'h1;
			if (i == 3 || i == 2) e[4] = 1'h0;
			if (i < 2) e = i ? e & 16'h0083 : 16'h0003;
			rf; chk("flags", {16'h0, e}, q);
		end
	endtask : t_flags
	task t_clk;
		apb(1'h1, RCS_OFF_CLKCFG, 32'h5); ev(9'h040);
		rs; chk("pin", 32'h5, q);
		apb(1'h1, RCS_OFF_CLKCFG, 32'hD); ev(9'h010);
		rs; chk("wdt", 32'h2, q);
		ev(9'h002); rs; chk("bor", 32'h5, q);
	endtask : t_clk
	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'h0;
		t_flags;
		t_clk;
		end_sim;
	end
	task end_sim;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
endmodule : rcs_reset_cause_test
